// ==== bench/pcs_host_model.sv ====
// Host output register model: latched character lines and end of line
`timescale 1ns/1ps
module pcs_host_model import pcs_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bench requests
  input wire logic load,
  input wire logic [CHAR_W-1:0] load_val,
  input wire logic eol_req,
  // Device side
  input wire logic latch_clear,
  output logic [CHAR_W-1:0] char_bits,
  output logic end_of_line
);
  logic [CHAR_W-1:0] lat_ff;
  logic eol_ff;
  // Lines stay set until quenched, like the host's latches
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lat_ff <= '0;
      eol_ff <= 1'b0;
    end else if (latch_clear) begin
      lat_ff <= '0;
      eol_ff <= 1'b0;
    end else begin
      if (load) lat_ff <= load_val;
      if (eol_req) eol_ff <= 1'b1;
    end
  end
  assign char_bits = lat_ff;
  assign end_of_line = eol_ff;
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the plot command sequencer
`timescale 1ns/1ps
module tb import pcs_pkg::*;;
  localparam int SC = 8, SB = 6, RC = 6, MC = 20, PC = 40;
  localparam logic [5:0] EXP [10] = '{6'h01, 6'h04, 6'h24, 6'h20, 6'h28, 6'h08, 6'h18,
    6'h10, 6'h14, 6'h02};
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, end_of_line, step_ack, ready_level, latch_clear;
  logic load = 0, eol_req = 0, ack_d = 0, side_bad = 0;
  logic [CHAR_W-1:0] load_val = '0, char_bits;
  pcs_cmd_t plot_cmd;
  logic [5:0] cmd_or = '0;
  int error_cnt = 0, comparisons = 0, cyc = 0, rise_cyc = 0, prev_rise = 0, n_rise = 0;
  int ack_w = 0, clr_w = 0, ack_len = 0, clr_len = 0, lat, t0, d, gap;
  logic prev_pen = 0;
  always #5 clk = ~clk;
  pcs_sequencer #(.SETTLE_CYC(24'(SC)), .STROBE_CYC(24'(SB)), .RESET_CYC(24'(RC)),
    .MOTION_CYC(24'(MC)), .MOTION_SCALED_CYC(24'h1e), .PEN_CYC(24'(PC)),
    .SCALED_MODEL(1'b0)) u_pcs_sequencer (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .char_bits(char_bits), .end_of_line(end_of_line),
    .step_ack(step_ack), .ready_level(ready_level), .latch_clear(latch_clear),
    .plot_cmd(plot_cmd));
  pcs_host_model u_pcs_host_model (.clk(clk), .nrst(nrst), .load(load), .load_val(load_val),
    .eol_req(eol_req), .latch_clear(latch_clear), .char_bits(char_bits),
    .end_of_line(end_of_line));
  // Pulse widths, rise times and side effects seen at the pins
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ack_d <= step_ack;
    if (step_ack && !ack_d) begin
      prev_rise <= rise_cyc;
      rise_cyc <= cyc;
      n_rise <= n_rise + 1;
      cmd_or <= plot_cmd;
    end else if (step_ack) cmd_or <= cmd_or | plot_cmd;
    ack_w <= step_ack ? ack_w + 1 : 0;
    if (!step_ack && ack_d) ack_len <= ack_w;
    clr_w <= latch_clear ? clr_w + 1 : 0;
    if (!latch_clear && clr_w != 0) clr_len <= clr_w;
    if (nrst && ((!step_ack && plot_cmd != 6'h00) || ready_level !== !step_ack))
      side_bad <= 1'b1;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // APB master, zero or more wait states
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task post(input logic [4:0] c, input logic e);
    @(posedge clk);
    if (e) eol_req <= 1;
    else begin load <= 1; load_val <= c; end
    t0 = cyc;
    @(posedge clk);
    load <= 0; eol_req <= 0;
  endtask
  task finish;
    while (!(step_ack === 1'b1 && ack_d === 1'b0)) @(posedge clk);
    @(posedge clk);
    lat = rise_cyc - t0;
    while (latch_clear !== 1'b1) @(posedge clk);
    while (latch_clear !== 1'b0) @(posedge clk);
    @(posedge clk);
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog at 20000 cycles, well past the roughly 400 cycles the sequence needs
  initial begin
    #200us;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1;
    chk("ready_rst", 1, ready_level);
    chk("ack_rst", 0, step_ack);
    apb(0, REG_CTRL, 0); chk("ctrl_rst", 0, rd);
    apb(1, REG_CTRL, 32'hffffffff); apb(0, REG_CTRL, 0); chk("ctrl_rw", 3, rd);
    apb(1, REG_STATUS, 32'hffffffff); chk("st_err", 0, er);
    apb(0, 8'h08, 0); chk("bad_err", 1, er); chk("bad_rd", 0, rd);
    apb(1, REG_CTRL, 0);
    // Character present but neither enable set: no cycle may start
    post(5'h02, 0);
    repeat (30) @(posedge clk);
    chk("blocked", 0, n_rise);
    apb(1, REG_CTRL, 32'h2);
    for (int i = 1; i <= 10; i++) begin
      d = i % 10;
      if (i == 10) apb(1, REG_CTRL, 32'h1);
      if (i > 1) post(d == 0 ? 5'h01 : 5'({4'(d), 1'b0}), 0);
      finish();
      if (i > 1) chk("settle", 1, lat >= SC + 1);
      chk("cmd", EXP[d], cmd_or);
      chk("ack_w", SB, ack_len);
      chk("clr_w", RC, clr_len);
      chk("held", 0, char_bits);
      // Lower bounds prove the timer, not the bench, set the spacing
      gap = rise_cyc - prev_rise;
      if (i > 1 && prev_pen) chk("gap_pen", 1, gap >= PC + SC);
      if (i > 1 && !prev_pen) chk("gap_mot", 1, gap >= MC + SC && gap < PC);
      prev_pen = (d == 9) || (d == 0);
    end
    // End of line while the pen timer still runs
    post(5'h00, 1);
    finish();
    chk("eol_fast", 1, lat < SC);
    chk("eol_cmd", 0, cmd_or);
    chk("eol_ack", SB, ack_len);
    chk("eol_clr", RC, clr_len);
    // Pen timer still busy after the end of line cycle
    apb(0, REG_STATUS, 0);
    chk("st_pen", 32'h1 << (ST_TMR_LO + TMR_PEN), rd);
    chk("side", 0, side_bad);
    conclude();
  end
endmodule

// ==== common/pcs_pkg.sv ====
// Constants and types shared by the plot command sequencer
package pcs_pkg;
  // Clock rate and counter width
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CNT_W = 24;
  // Printed times, in their own units
  localparam int unsigned SETTLE_US = 100;
  localparam int unsigned STROBE_US = 50;
  localparam int unsigned RESET_US = 60;
  localparam int unsigned MOTION_US = 3400;
  localparam int unsigned MOTION_SCALED_US = 5000;
  localparam int unsigned PEN_US = 100000;
  // Cycle counts derived from the times
  localparam logic [CNT_W-1:0] SETTLE_CYC_D = CNT_W'(SETTLE_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] STROBE_CYC_D = CNT_W'(STROBE_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] RESET_CYC_D = CNT_W'(RESET_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] MOTION_CYC_D = CNT_W'(MOTION_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] MOTION_SCALED_CYC_D = CNT_W'(MOTION_SCALED_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] PEN_CYC_D = CNT_W'(PEN_US * CLK_MHZ);
  // Character bit lines: zero line plus 8-4-2-1
  localparam int unsigned CHAR_W = 5;
  localparam int unsigned CHAR_ZERO = 0;
  localparam int unsigned CHAR_BCD_LO = 1;
  localparam int unsigned CHAR_BCD_HI = 4;
  localparam int unsigned NUM_DIGITS = 10;
  localparam int unsigned TMR_MOTION = 0;
  localparam int unsigned TMR_PEN = 1;
  // Register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int unsigned CTRL_OFFLINE = 0;
  localparam int unsigned CTRL_METER = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int unsigned ST_STATE_LO = 0;
  localparam int unsigned ST_TMR_LO = 2;
  localparam int unsigned ST_EOL = 4;
  localparam int unsigned ST_CHAR_LO = 8;
  // Sequencer states
  typedef enum logic [1:0] {
    PCS_IDLE,
    PCS_SETTLE,
    PCS_STROBE,
    PCS_RESET
  } pcs_state_t;
  // Plotter command bundle
  typedef struct packed {
    logic drum_up;
    logic drum_down;
    logic carr_left;
    logic carr_right;
    logic pen_up;
    logic pen_down;
  } pcs_cmd_t;
endpackage

// ==== logic/pcs_sequencer.sv ====
// Plot command sequencer: decode, strobe, acknowledge, latch clear, delay timers
`timescale 1ns/1ps
module pcs_sequencer import pcs_pkg::*; #(
  parameter logic [CNT_W-1:0] SETTLE_CYC = SETTLE_CYC_D,
  parameter logic [CNT_W-1:0] STROBE_CYC = STROBE_CYC_D,
  parameter logic [CNT_W-1:0] RESET_CYC = RESET_CYC_D,
  parameter logic [CNT_W-1:0] MOTION_CYC = MOTION_CYC_D,
  parameter logic [CNT_W-1:0] MOTION_SCALED_CYC = MOTION_SCALED_CYC_D,
  parameter logic [CNT_W-1:0] PEN_CYC = PEN_CYC_D,
  parameter bit SCALED_MODEL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host side
  input wire logic [CHAR_W-1:0] char_bits,
  input wire logic end_of_line,
  output logic step_ack,
  output logic ready_level,
  output logic latch_clear,
  // Plotter side
  output pcs_cmd_t plot_cmd
);

  // Pin synchronisers; first stage is read only by the second
  logic [CHAR_W:0] sync1_ff;
  logic [CHAR_W:0] sync2_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {end_of_line, char_bits};
      sync2_ff <= sync1_ff;
    end
  end
  logic eol_s;
  logic [CHAR_W-1:0] bits_s;
  assign eol_s = sync2_ff[CHAR_W];
  assign bits_s = sync2_ff[CHAR_W-1:0];

  // Control register bits
  logic [1:0] ctrl_ff;

  // Sequencer state
  pcs_state_t state_ff;
  pcs_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic start_dly_ff;
  logic eol_cyc_ff;
  logic nxt_eol_cyc;
  logic [CHAR_W-1:0] char_ff;
  logic [1:0] tbusy;
  logic can_start;

  assign can_start = (tbusy == 2'h0) && (ctrl_ff[CTRL_OFFLINE] || ctrl_ff[CTRL_METER])
                     && (bits_s != '0);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_eol_cyc = eol_cyc_ff;
    case (state_ff)
      PCS_IDLE: begin
        if (eol_s) begin
          nxt_state = PCS_STROBE;
          nxt_cnt = STROBE_CYC - 1'b1;
          nxt_eol_cyc = 1'b1;
        end else if (can_start) begin
          nxt_state = PCS_SETTLE;
          nxt_cnt = SETTLE_CYC - 1'b1;
        end
      end
      PCS_SETTLE: begin
        if (cnt_ff == '0 && start_dly_ff) begin
          nxt_state = PCS_STROBE;
          nxt_cnt = STROBE_CYC - 1'b1;
        end else if (cnt_ff != '0) begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      PCS_STROBE: begin
        if (cnt_ff == '0) begin
          nxt_state = PCS_RESET;
          nxt_cnt = RESET_CYC - 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      PCS_RESET: begin
        if (cnt_ff == '0) begin
          nxt_state = PCS_IDLE;
          nxt_eol_cyc = 1'b0;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = PCS_IDLE;
        nxt_cnt = '0;
        nxt_eol_cyc = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= PCS_IDLE;
      cnt_ff <= '0;
      eol_cyc_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      eol_cyc_ff <= nxt_eol_cyc;
    end
  end

  // Start edge rises only once the settle interval is running
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_dly_ff <= 1'b0;
    end else begin
      start_dly_ff <= (state_ff == PCS_SETTLE);
    end
  end

  // Captured character; held through the strobe, dropped with the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      char_ff <= '0;
    end else if (state_ff == PCS_IDLE && nxt_state == PCS_SETTLE) begin
      char_ff <= bits_s;
    end else if (state_ff == PCS_RESET && cnt_ff == '0) begin
      char_ff <= '0;
    end
  end

  // One-hot digit decode
  logic [NUM_DIGITS-1:0] digit;
  logic [3:0] bcd;
  assign bcd = char_ff[CHAR_BCD_HI:CHAR_BCD_LO];
  generate
    for (genvar d = 0; d < NUM_DIGITS; d++) begin : g_dec
      if (d == 0) begin : g_zero
        assign digit[d] = char_ff[CHAR_ZERO];
      end else begin : g_num
        assign digit[d] = !char_ff[CHAR_ZERO] && (bcd == 4'(d));
      end
    end
  endgenerate

  // Eight directions round the compass, then pen
  pcs_cmd_t cmd;
  assign cmd.carr_right = digit[1] | digit[2] | digit[8];
  assign cmd.drum_up = digit[2] | digit[3] | digit[4];
  assign cmd.carr_left = digit[4] | digit[5] | digit[6];
  assign cmd.drum_down = digit[6] | digit[7] | digit[8];
  assign cmd.pen_up = digit[9];
  assign cmd.pen_down = digit[0];

  logic pen_char;
  assign pen_char = digit[0] | digit[9];

  // Timer start pulse: last cycle before the first strobe cycle
  logic tmr_start;
  assign tmr_start = (state_ff != PCS_STROBE) && (nxt_state == PCS_STROBE);
  logic [1:0] trig;
  assign trig[TMR_PEN] = tmr_start && pen_char && !nxt_eol_cyc;
  assign trig[TMR_MOTION] = tmr_start && !pen_char && !nxt_eol_cyc;

  // Two stages in series so neither runs more than half the delay
  localparam logic [CNT_W-1:0] MOT_FULL = SCALED_MODEL ? MOTION_SCALED_CYC : MOTION_CYC;
  generate
    for (genvar t = 0; t < 2; t++) begin : g_tmr
      localparam logic [CNT_W-1:0] HALF = (t == TMR_PEN) ? (PEN_CYC >> 1) : (MOT_FULL >> 1);
      logic [1:0] stage_ff;
      logic [CNT_W-1:0] tcnt_ff;
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          stage_ff <= 2'h0;
          tcnt_ff <= '0;
        end else if (trig[t]) begin
          stage_ff <= 2'h1;
          tcnt_ff <= HALF - 1'b1;
        end else if (stage_ff != 2'h0) begin
          if (tcnt_ff != '0) begin
            tcnt_ff <= tcnt_ff - 1'b1;
          end else if (stage_ff == 2'h1) begin
            stage_ff <= 2'h2;
            tcnt_ff <= HALF - 1'b1;
          end else begin
            stage_ff <= 2'h0;
          end
        end
      end
      assign tbusy[t] = (stage_ff != 2'h0);
    end
  endgenerate

  // Host and plotter outputs, registered from the next state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      step_ack <= 1'b0;
      ready_level <= 1'b1;
      latch_clear <= 1'b0;
      plot_cmd <= '0;
    end else begin
      step_ack <= (nxt_state == PCS_STROBE);
      ready_level <= (nxt_state != PCS_STROBE);
      latch_clear <= (nxt_state == PCS_RESET);
      plot_cmd <= (nxt_state == PCS_STROBE && !nxt_eol_cyc) ? cmd : '0;
    end
  end

  // APB slave: one wait-free access, answer registered in setup
  logic setup;
  logic hit_ctrl;
  logic hit_stat;
  assign setup = psel && !penable;
  assign hit_ctrl = (paddr == REG_CTRL);
  assign hit_stat = (paddr == REG_STATUS);
  logic [31:0] stat_word;
  always_comb begin
    stat_word = '0;
    stat_word[ST_STATE_LO +: 2] = state_ff;
    stat_word[ST_TMR_LO +: 2] = tbusy;
    stat_word[ST_EOL] = eol_cyc_ff;
    stat_word[ST_CHAR_LO +: CHAR_W] = char_ff;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup && !hit_ctrl && !hit_stat;
      if (setup && !pwrite) begin
        prdata <= hit_ctrl ? {30'h0, ctrl_ff} : (hit_stat ? stat_word : 32'h0);
      end else if (!psel) begin
        prdata <= '0;
      end
    end
  end

  // Offline and meter switches live in software reach
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= CTRL_RST;
    end else if (psel && penable && pready && pwrite && hit_ctrl) begin
      ctrl_ff <= pwdata[1:0];
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_strobe_end;
    step_ack ##1 !step_ack;
  endsequence
  sequence s_settle_begin;
    state_ff == PCS_IDLE ##1 state_ff == PCS_SETTLE;
  endsequence

  a_ready_inverse: assert property (ready_level == !step_ack)
    else $error("ready level not inverse of step ack");
  a_start_gate: assert property (s_settle_begin |-> $past(tbusy) == 2'h0 &&
    $past(bits_s) != '0)
    else $error("cycle started while blocked");
  a_settle_len: assert property (s_settle_begin |-> cnt_ff == SETTLE_CYC - 1'b1)
    else $error("settle interval has wrong length");
  a_start_delay: assert property (s_settle_begin |-> !start_dly_ff ##1 start_dly_ff)
    else $error("start edge not delayed");
  a_strobe_fire: assert property (state_ff == PCS_SETTLE && cnt_ff == '0 |=> step_ack)
    else $error("strobe missing after settle");
  a_strobe_len: assert property ($rose(step_ack) |-> cnt_ff == STROBE_CYC - 1'b1)
    else $error("strobe has wrong length");
  a_cmd_gated: assert property (!step_ack || eol_cyc_ff |-> plot_cmd == '0)
    else $error("command outside strobe");
  a_char_held: assert property (state_ff == PCS_STROBE |-> $stable(char_ff))
    else $error("character changed during strobe");
  a_reset_follow: assert property (s_strobe_end |-> latch_clear &&
    cnt_ff == RESET_CYC - 1'b1)
    else $error("reset pulse missing after strobe");
  a_clear_chars: assert property (state_ff == PCS_RESET && cnt_ff == '0 |=>
    char_ff == '0 && !latch_clear)
    else $error("characters not cleared");
  a_pen_trig: assert property (trig[TMR_PEN] |=> g_tmr[TMR_PEN].stage_ff == 2'h1)
    else $error("pen timer not started");
  // Entry cycle counts too: the registered flag alone rises one cycle late
  a_eol_no_tmr: assert property (eol_cyc_ff || (state_ff == PCS_IDLE && eol_s) |->
    trig == 2'h0)
    else $error("timer started on end of line");
  a_stage_swap: assert property (g_tmr[TMR_MOTION].stage_ff == 2'h1 &&
    g_tmr[TMR_MOTION].tcnt_ff == '0 && !trig[TMR_MOTION] |=>
    g_tmr[TMR_MOTION].stage_ff == 2'h2)
    else $error("second stage not entered");
  // Software enable must stand before a character cycle may open
  a_start_enable: assert property (s_settle_begin |-> $past(ctrl_ff) != 2'h0)
    else $error("cycle started with both switches off");
  // A running timer holds off character cycles; end of line may still pass
  a_tmr_block: assert property (state_ff == PCS_IDLE && |tbusy && !eol_s |=>
    state_ff != PCS_SETTLE)
    else $error("cycle started while timer busy");
  a_cmd_strobe: assert property (step_ack && !eol_cyc_ff |-> plot_cmd == cmd)
    else $error("command differs from decode during strobe");
  // Motion half length follows the model parameter
  a_mot_trig: assert property (trig[TMR_MOTION] |=>
    g_tmr[TMR_MOTION].stage_ff == 2'h1 &&
    g_tmr[TMR_MOTION].tcnt_ff == (MOT_FULL >> 1) - 1'b1)
    else $error("motion timer not started with half delay");

endmodule
